// ===== rtcs_pkg.sv
`default_nettype none
package rtcs_pkg;

    // ****************************************************************
    // Register offsets (page 0) and page switch location
    // ****************************************************************
    localparam logic [7:0] ADDR_XCVR_CTRL = 8'h80;
    localparam logic [7:0] ADDR_FAULT_STAT = 8'h81;
    localparam logic [7:0] ADDR_RX_POL = 8'h97;
    localparam logic [7:0] ADDR_PAGE_SEL = 8'hff;
    localparam logic [1:0] PAGE_REGS = 2'h0;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTL_MASTER = 7;
    localparam int CTL_TX_OE = 6;
    localparam int CTL_RSVD5 = 5;
    localparam int CTL_WAKE = 4;
    localparam int CTL_STANDALONE = 3;
    localparam int CTL_SYNC_BYP = 2;
    localparam int CTL_FULL_BYP_N = 1;
    localparam int CTL_RCLK_TRI = 0;

    localparam int ST_MASK_SPDIF = 6;
    localparam int ST_MASK_LOCK = 5;
    localparam int ST_MASK_CODE = 4;
    localparam int ST_FAULT = 3;
    localparam int ST_SPDIF_CAP = 1;
    localparam int ST_LOCK_CAP = 0;

    localparam int POL_RX = 1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic RST_RSVD5 = 1'b1;
    localparam logic RST_MASK_SPDIF = 1'b1;
    localparam logic RST_MASK_LOCK = 1'b0;
    localparam logic RST_MASK_CODE = 1'b1;
    localparam logic RST_RX_POL = 1'b0;

    // ****************************************************************
    // Synchronous data delay through an active node, in frames
    // ****************************************************************
    localparam logic [1:0] SYNC_DELAY_FRAMES = 2'h2;
    localparam logic [1:0] SYNC_DELAY_NONE = 2'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int WAKE_TIME_NS = 1000;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Serial port byte phases
    // ****************************************************************
    typedef enum logic [1:0] {
        RTCS_PH_ADDR,
        RTCS_PH_MAP,
        RTCS_PH_WDATA,
        RTCS_PH_RDATA
    } rtcs_phase_t;

endpackage
`default_nettype wire

// ===== rtcs_spi_port.sv
`timescale 1ns/1ps
`default_nettype none
module rtcs_spi_port
    import rtcs_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_scl,
    input wire logic spi_sdin,
    output logic spi_sdout_o,
    output logic spi_sdout_oe,
    output logic wr_pulse,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);

    logic scl_q_r;
    logic cs_q_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] rx_sh_r;
    logic [7:0] tx_sh_r;
    logic [7:0] map_r;
    rtcs_phase_t phase_r;
    logic wr_pulse_r;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic scl_rise;
    logic scl_fall;
    logic cs_start;
    logic active;
    logic [7:0] byte_in;

    assign active = ~spi_cs_n;
    assign scl_rise = active & spi_scl & ~scl_q_r;
    assign scl_fall = active & ~spi_scl & scl_q_r;
    assign cs_start = cs_q_r & ~spi_cs_n;
    assign byte_in = {rx_sh_r[6:0], spi_sdin};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scl_q_r <= 1'b0;
            cs_q_r <= 1'b1;
        end else begin
            scl_q_r <= spi_scl;
            cs_q_r <= spi_cs_n;
        end
    end

    // ****************************************************************
    // Byte framing: address byte, pointer byte, then data
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 8'h00;
            phase_r <= RTCS_PH_ADDR;
            map_r <= 8'h00;
            tx_sh_r <= 8'h00;
            wr_pulse_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            wr_pulse_r <= 1'b0;
            if (cs_start) begin
                bit_cnt_r <= 3'h0;
                phase_r <= RTCS_PH_ADDR;
            end else if (scl_rise) begin
                rx_sh_r <= byte_in;
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7) begin
                    unique case (phase_r)
                        RTCS_PH_ADDR: begin
                            phase_r <= byte_in[0] ? RTCS_PH_RDATA : RTCS_PH_MAP;
                        end
                        RTCS_PH_MAP: begin
                            map_r <= byte_in;
                            phase_r <= RTCS_PH_WDATA;
                        end
                        RTCS_PH_WDATA: begin
                            wr_pulse_r <= 1'b1;
                            wr_addr_r <= map_r;
                            wr_data_r <= byte_in;
                            map_r <= map_r + 8'h01;
                        end
                        RTCS_PH_RDATA: begin
                        end
                    endcase
                end
            end else if (scl_fall && phase_r == RTCS_PH_RDATA) begin
                if (bit_cnt_r == 3'h0) begin
                    // Fetch next byte at the boundary, pointer wraps
                    tx_sh_r <= rd_data;
                    map_r <= map_r + 8'h01;
                end else begin
                    tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                end
            end
        end
    end

    assign rd_addr = map_r;
    assign spi_sdout_o = tx_sh_r[7];
    assign spi_sdout_oe = active & (phase_r == RTCS_PH_RDATA);
    assign wr_pulse = wr_pulse_r;
    assign wr_addr = wr_addr_r;
    assign wr_data = wr_data_r;

endmodule // rtcs_spi_port
`default_nettype wire

// ===== rtcs_ctrl_status.sv
`timescale 1ns/1ps
`default_nettype none
module rtcs_ctrl_status
    import rtcs_pkg::*;
#(
    parameter int WAKE_LEN = WAKE_CYCLES,
    parameter logic [1:0] SRC_RECOVERED = 2'h0
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_scl,
    input wire logic spi_sdin,
    output logic spi_sdout_o,
    output logic spi_sdout_oe,
    input wire logic host_read_strobe_n,
    input wire logic host_store_strobe_n,
    input wire logic rx_pin,
    output logic rx_data,
    input wire logic node_tx_data,
    output logic tx_pin,
    input wire logic [1:0] timing_source_select,
    output logic master_mode,
    output logic [1:0] active_timing_source,
    output logic wake_signal,
    output logic sync_bypass,
    output logic sync_routing_allow,
    output logic [1:0] sync_delay_frames,
    output logic node_delay_increment,
    output logic node_active,
    output logic node_position_increment,
    input wire logic divided_clock,
    output logic recovered_clock_pin_o,
    output logic recovered_clock_pin_oe,
    input wire logic spdif_lock_error,
    input wire logic lock_error,
    input wire logic lock_status,
    input wire logic coding_error,
    output logic fault_pin,
    input wire logic fault_irq_enable,
    input wire logic fault_irq_reset,
    output logic irq_n
);

    // ****************************************************************
    // Serial control port
    // ****************************************************************
    logic wr_pulse;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;

    rtcs_spi_port u_port (
        .clock(clock),
        .rst(rst),
        .spi_cs_n(spi_cs_n),
        .spi_scl(spi_scl),
        .spi_sdin(spi_sdin),
        .spi_sdout_o(spi_sdout_o),
        .spi_sdout_oe(spi_sdout_oe),
        .wr_pulse(wr_pulse),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    logic [1:0] page_r;
    logic on_page;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_pol;

    assign on_page = (page_r == PAGE_REGS);
    assign wr_ctrl = wr_pulse & on_page & (wr_addr == ADDR_XCVR_CTRL);
    assign wr_stat = wr_pulse & on_page & (wr_addr == ADDR_FAULT_STAT);
    assign wr_pol = wr_pulse & on_page & (wr_addr == ADDR_RX_POL);

    // Page switch lives at the same location on every page
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            page_r <= PAGE_REGS;
        end else if (wr_pulse && wr_addr == ADDR_PAGE_SEL) begin
            page_r <= wr_data[1:0];
        end
    end

    // ****************************************************************
    // Transceiver control register
    // ****************************************************************
    logic master_r;
    logic tx_oe_r;
    logic rsvd5_r;
    logic sync_byp_r;
    logic full_byp_n_r;
    logic rclk_tri_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            master_r <= 1'b0;
            tx_oe_r <= 1'b0;
            rsvd5_r <= RST_RSVD5;
            sync_byp_r <= 1'b0;
            full_byp_n_r <= 1'b0;
            rclk_tri_r <= 1'b0;
        end else if (wr_ctrl) begin
            master_r <= wr_data[CTL_MASTER];
            tx_oe_r <= wr_data[CTL_TX_OE];
            rsvd5_r <= wr_data[CTL_RSVD5];
            sync_byp_r <= wr_data[CTL_SYNC_BYP];
            full_byp_n_r <= wr_data[CTL_FULL_BYP_N];
            rclk_tri_r <= wr_data[CTL_RCLK_TRI];
        end
    end

    // ****************************************************************
    // Stand-alone strap, caught on the first edge after release
    // ****************************************************************
    logic strap_done_r;
    logic standalone_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_done_r <= 1'b0;
            standalone_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            standalone_r <= ~host_read_strobe_n & ~host_store_strobe_n;
        end
    end

    // ****************************************************************
    // Low-power wake-up generator
    // ****************************************************************
    logic [15:0] wake_cnt_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_cnt_r <= 16'h0000;
        end else if (wr_ctrl && wr_data[CTL_WAKE] && master_r) begin
            wake_cnt_r <= 16'(WAKE_LEN);
        end else if (wake_cnt_r != 16'h0000) begin
            wake_cnt_r <= wake_cnt_r - 16'h0001;
        end
    end

    assign wake_signal = (wake_cnt_r != 16'h0000);

    // ****************************************************************
    // Network data path
    // ****************************************************************
    logic pol_r;
    logic rx_data_r;
    logic tx_pin_r;
    logic rclk_r;
    logic [1:0] tsrc_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_data_r <= 1'b0;
            tx_pin_r <= 1'b0;
        end else begin
            rx_data_r <= rx_pin ^ pol_r;
            if (!full_byp_n_r) begin
                tx_pin_r <= rx_pin;
            end else begin
                tx_pin_r <= tx_oe_r & node_tx_data;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tsrc_r <= SRC_RECOVERED;
        end else begin
            tsrc_r <= master_r ? timing_source_select : SRC_RECOVERED;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rclk_r <= 1'b0;
        end else begin
            rclk_r <= divided_clock;
        end
    end

    assign rx_data = rx_data_r;
    assign tx_pin = tx_pin_r;
    assign master_mode = master_r;
    assign active_timing_source = tsrc_r;
    assign recovered_clock_pin_o = rclk_r;
    assign recovered_clock_pin_oe = ~rclk_tri_r;

    assign sync_bypass = sync_byp_r;
    assign node_delay_increment = full_byp_n_r & ~sync_byp_r;
    assign sync_delay_frames = node_delay_increment ? SYNC_DELAY_FRAMES : SYNC_DELAY_NONE;
    assign sync_routing_allow = node_delay_increment;
    assign node_active = full_byp_n_r;
    assign node_position_increment = full_byp_n_r;

    // ****************************************************************
    // Error events and masks
    // ****************************************************************
    logic lock_q_r;
    logic xcvr_event;
    logic fault_event;
    logic mask_spdif_r;
    logic mask_lock_r;
    logic mask_code_r;
    logic fault_r;
    logic spdif_cap_r;
    logic lock_cap_r;
    logic fault_pin_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_q_r <= 1'b0;
        end else begin
            lock_q_r <= lock_status;
        end
    end

    assign xcvr_event = lock_error | (lock_status & ~lock_q_r);

    assign fault_event = (spdif_lock_error & ~mask_spdif_r)
        | (xcvr_event & ~mask_lock_r)
        | (coding_error & ~mask_code_r);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_spdif_r <= RST_MASK_SPDIF;
            mask_lock_r <= RST_MASK_LOCK;
            mask_code_r <= RST_MASK_CODE;
        end else if (wr_stat) begin
            mask_spdif_r <= wr_data[ST_MASK_SPDIF];
            mask_lock_r <= wr_data[ST_MASK_LOCK];
            mask_code_r <= wr_data[ST_MASK_CODE];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_r <= 1'b0;
        end else if (fault_event) begin
            fault_r <= 1'b1;
        end else if (wr_stat && !wr_data[ST_FAULT]) begin
            fault_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            spdif_cap_r <= 1'b0;
            lock_cap_r <= 1'b0;
        end else begin
            if (spdif_lock_error) begin
                spdif_cap_r <= 1'b1;
            end else if (wr_stat && !wr_data[ST_SPDIF_CAP]) begin
                spdif_cap_r <= 1'b0;
            end
            if (xcvr_event) begin
                lock_cap_r <= 1'b1;
            end else if (wr_stat && !wr_data[ST_LOCK_CAP]) begin
                lock_cap_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_pin_r <= 1'b0;
        end else begin
            fault_pin_r <= fault_event;
        end
    end

    assign fault_pin = fault_pin_r;

    // ****************************************************************
    // Fault interrupt
    // ****************************************************************
    logic irq_arm_r;
    logic irq_n_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_arm_r <= 1'b0;
        end else if (fault_event) begin
            irq_arm_r <= 1'b1;
        end else if (fault_irq_reset) begin
            irq_arm_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= ~(fault_r & fault_irq_enable & irq_arm_r);
        end
    end

    assign irq_n = irq_n_r;

    // ****************************************************************
    // Receive polarity register
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pol_r <= RST_RX_POL;
        end else if (wr_pol) begin
            pol_r <= wr_data[POL_RX];
        end
    end

    // ****************************************************************
    // Read-back
    // ****************************************************************
    always_comb begin
        rd_data = 8'h00;
        if (rd_addr == ADDR_PAGE_SEL) begin
            rd_data = {6'h00, page_r};
        end else if (on_page && rd_addr == ADDR_XCVR_CTRL) begin
            rd_data[CTL_MASTER] = master_r;
            rd_data[CTL_TX_OE] = tx_oe_r;
            rd_data[CTL_RSVD5] = rsvd5_r;
            rd_data[CTL_WAKE] = 1'b0;
            rd_data[CTL_STANDALONE] = standalone_r;
            rd_data[CTL_SYNC_BYP] = sync_byp_r;
            rd_data[CTL_FULL_BYP_N] = full_byp_n_r;
            rd_data[CTL_RCLK_TRI] = rclk_tri_r;
        end else if (on_page && rd_addr == ADDR_FAULT_STAT) begin
            rd_data[ST_MASK_SPDIF] = mask_spdif_r;
            rd_data[ST_MASK_LOCK] = mask_lock_r;
            rd_data[ST_MASK_CODE] = mask_code_r;
            rd_data[ST_FAULT] = fault_r;
            rd_data[ST_SPDIF_CAP] = spdif_cap_r;
            rd_data[ST_LOCK_CAP] = lock_cap_r;
        end else if (on_page && rd_addr == ADDR_RX_POL) begin
            rd_data[POL_RX] = pol_r;
        end
    end

endmodule // rtcs_ctrl_status
`default_nettype wire

// ===== rtcs_ctrl_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rtcs_ctrl_status_chk
    import rtcs_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic rx_pin,
    input wire logic node_tx_data,
    input wire logic tx_pin,
    input wire logic node_active,
    input wire logic sync_bypass,
    input wire logic [1:0] sync_delay_frames,
    input wire logic node_delay_increment,
    input wire logic node_position_increment,
    input wire logic master_mode,
    input wire logic [1:0] timing_source_select,
    input wire logic [1:0] active_timing_source,
    input wire logic wake_signal,
    input wire logic spdif_lock_error,
    input wire logic lock_error,
    input wire logic lock_status,
    input wire logic coding_error,
    input wire logic fault_pin,
    input wire logic fault_irq_reset,
    input wire logic irq_n
);
    // ****
    // Port relations
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic ev;
    assign ev = spdif_lock_error | lock_error | coding_error | lock_status;
    tx_byp_a: assert property (
        $past(!node_active && !rst) |-> tx_pin == $past(rx_pin)) else $error("tx bypass");
    tx_low_a: assert property (
        $past(node_active && !node_tx_data) |-> !tx_pin) else $error("tx not low");
    sync_dly_a: assert property (
        node_delay_increment == (node_active && !sync_bypass)) else $error("delay count");
    sync_frm_a: assert property (
        sync_delay_frames == (node_delay_increment ? SYNC_DELAY_FRAMES : SYNC_DELAY_NONE))
        else $error("frame delay");
    node_pos_a: assert property (
        node_position_increment == node_active) else $error("position count");
    tim_src_a: assert property (
        active_timing_source == ($past(master_mode) ? $past(timing_source_select) : 2'h0))
        else $error("timing source");
    wake_mst_a: assert property (
        $rose(wake_signal) |-> master_mode) else $error("wake in slave");
    flt_live_a: assert property (
        !$past(ev) |-> !fault_pin) else $error("fault pin stuck");
    irq_rel_a: assert property (
        fault_irq_reset && !ev ##1 !ev |=> irq_n) else $error("irq not released");
    flt_c: cover property (fault_pin);
    irq_c: cover property (!irq_n);
    wake_c: cover property (wake_signal);
endmodule // rtcs_ctrl_status_chk
bind rtcs_ctrl_status rtcs_ctrl_status_chk u_chk (.*);
`default_nettype wire

// ===== rtcs_net_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtcs_net_model (
    input wire logic clock,
    input wire logic [3:0] ev_cmd,
    output logic rx_pin,
    output logic spdif_lock_error,
    output logic lock_error,
    output logic coding_error,
    output logic lock_status
);
    initial {rx_pin, lock_status, coding_error, lock_error, spdif_lock_error} = 5'h00;
    // Line and events move 5 ns after the rising edge, clear of sampling
    always @(posedge clock) begin
        #5;
        rx_pin <= 1'($urandom);
        {lock_status, coding_error, lock_error, spdif_lock_error} <= ev_cmd;
    end
endmodule // rtcs_net_model
`default_nettype wire

// ===== ring_transceiver_ctrl_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module ring_transceiver_ctrl_status_tb;
    import rtcs_pkg::*;
    logic clock, rst, cs_n, scl, sdin, sdo, str_n, ntx, rxp, rxd, txp, mm, ws, wk;
    logic sb, na, roe, fir, irq_n, se, le, ce, ls, p, fie;
    logic [1:0] tsel;
    logic [3:0] ev;
    logic [7:0] r, e, k, m;
    int err_count, n_checks, c, mb;
    rtcs_ctrl_status #(.WAKE_LEN(3)) DUT (
        .clock(clock), .rst(rst), .spi_cs_n(cs_n), .spi_scl(scl), .spi_sdin(sdin),
        .spi_sdout_o(sdo), .spi_sdout_oe(), .host_read_strobe_n(str_n),
        .host_store_strobe_n(str_n), .rx_pin(rxp), .rx_data(rxd), .node_tx_data(ntx),
        .tx_pin(txp), .timing_source_select(tsel), .master_mode(mm),
        .active_timing_source(), .wake_signal(wk), .sync_bypass(sb),
        .sync_routing_allow(), .sync_delay_frames(), .node_delay_increment(),
        .node_active(na), .node_position_increment(), .divided_clock(ntx),
        .recovered_clock_pin_o(), .recovered_clock_pin_oe(roe), .spdif_lock_error(se),
        .lock_error(le), .lock_status(ls), .coding_error(ce), .fault_pin(),
        .fault_irq_enable(fie), .fault_irq_reset(fir), .irq_n(irq_n));
    rtcs_net_model u_net (.clock(clock), .ev_cmd(ev), .rx_pin(rxp), .spdif_lock_error(se),
        .lock_error(le), .coding_error(ce), .lock_status(ls));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) if (wk) ws <= 1'b1;
    // ****
    // Serial port access
    // ****
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic sbyte(input logic [7:0] w, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            sdin = w[i];
            tk(2);
            scl = 1'b1;
            tk(2);
            q[i] = sdo;
            scl = 1'b0;
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd_op);
        logic [7:0] q;
        cs_n = 1'b0;
        tk(2);
        sbyte(8'h00, q);
        sbyte(a, q);
        if (rd_op) begin
            cs_n = 1'b1;
            tk(3);
            cs_n = 1'b0;
            tk(2);
            sbyte(8'h01, q);
        end
        sbyte(d, r);
        tk(4);
        cs_n = 1'b1;
        tk(3);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        xfer(a, 8'h00, 1'b1);
        `CHK("rdata", x, r)
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #2ms;
        err_count++;
        wrap_up;
    end
    // ****
    // Tests
    // ****
    initial begin
        {rst, cs_n, str_n, scl, sdin, ntx, fir, tsel, ev} = 13'h1c00;
        fie = 1'b1;
        void'($urandom(13978));
        tk(6);
        rst = 1'b0;
        tk(3);
        rd(ADDR_XCVR_CTRL, 8'h20);
        rd(ADDR_FAULT_STAT, 8'h50);
        rd(ADDR_RX_POL, 8'h00);
        xfer(8'h85, 8'h5a, 1'b0);
        rd(8'h85, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            m = (8'($urandom) & 8'hc7) | 8'h20;
            tsel = 2'($urandom);
            xfer(ADDR_XCVR_CTRL, m, 1'b0);
            rd(ADDR_XCVR_CTRL, m);
            `CHK("mode", {m[7], m[1], m[2], ~m[0]}, {mm, na, sb, roe})
        end
        xfer(ADDR_XCVR_CTRL, 8'ha0, 1'b0);
        ws = 1'b0;
        xfer(ADDR_XCVR_CTRL, 8'hb0, 1'b0);
        `CHK("wake", 1'b1, ws)
        rd(ADDR_XCVR_CTRL, 8'ha0);
        xfer(ADDR_XCVR_CTRL, 8'h20, 1'b0);
        ws = 1'b0;
        xfer(ADDR_XCVR_CTRL, 8'h30, 1'b0);
        `CHK("wake", 1'b0, ws)
        $display("control test done");
        for (c = 0; c < 2; c++) begin
            p = (c == 0);
            xfer(ADDR_XCVR_CTRL, p ? 8'h62 : 8'h22, 1'b0);
            xfer(ADDR_RX_POL, {6'h00, p, 1'b0}, 1'b0);
            rd(ADDR_RX_POL, {6'h00, p, 1'b0});
            for (int i = 0; i < 6; i++) begin
                ntx = 1'($urandom);
                tk(1);
                `CHK("path", {rxp ^ p, ntx & p}, {rxd, txp})
            end
        end
        $display("data path test done");
        for (int i = 0; i < 8; i++) begin
            c = i % 4;
            m = (i < 4) ? 8'h00 : 8'h70;
            fie = (i != 2);
            xfer(ADDR_FAULT_STAT, m, 1'b0);
            fir = 1'b1;
            tk(1);
            fir = 1'b0;
            ev = 4'(1 << c);
            tk(3);
            fir = 1'b1;
            tk(1);
            fir = 1'b0;
            tk(3);
            ev = 4'h0;
            tk(3);
            mb = (c == 0) ? 6 : (c == 2) ? 4 : 5;
            e = m | {4'h0, ~m[mb], 1'b0, c == 0, (c == 1) || (c == 3)};
            k = 8'hff;
            `CHK("irq", !(e[3] && c != 3 && fie), irq_n)
            xfer(ADDR_FAULT_STAT, 8'h00, 1'b1);
            `CHK("status", e & k, r & k)
            xfer(ADDR_FAULT_STAT, e | 8'h0b, 1'b0);
            xfer(ADDR_FAULT_STAT, 8'h00, 1'b1);
            `CHK("status", e & k, r & k)
        end
        $display("error test done");
        {rst, str_n} = 2'b10;
        tk(6);
        rst = 1'b0;
        tk(3);
        str_n = 1'b1;
        rd(ADDR_XCVR_CTRL, 8'h28);
        xfer(ADDR_XCVR_CTRL, 8'h28, 1'b0);
        rd(ADDR_XCVR_CTRL, 8'h28);
        rd(ADDR_FAULT_STAT, 8'h50);
        $display("standalone test done");
        wrap_up;
    end
endmodule // ring_transceiver_ctrl_status_tb
`default_nettype wire
